// >>> hw/lcsi_pkg.sv
// Purpose: Shared constants and carrier types for the line-interface channel logic.
// Assumes: Register clock CLK at 100 MHz; link clock at 16x the line bit rate.
// Notes:   Control fields are laid out by the lcsi_cfg_s struct, msb first.
package lcsi_pkg;
  localparam int NCH = 4;
  localparam int AW  = 3;
  localparam logic [AW-1:0] ADDR_CTRL   = 3'h0;
  localparam logic [AW-1:0] ADDR_STATUS = 3'h1;
  localparam logic [AW-1:0] ADDR_ERR_LO = 3'h2;
  localparam logic [AW-1:0] ADDR_ERR_HI = 3'h3;
  localparam logic [AW-1:0] ADDR_SER_RX = 3'h4;
  localparam logic [AW-1:0] ADDR_SER_TX = 3'h5;
  localparam logic [7:0]    CTRL_RST    = 8'h00;
  localparam logic [15:0]   ERRCNT_RST  = 16'h0000;
  localparam logic [7:0]    SER_RST     = 8'h00;
  // Loss-of-transmit-clock time, rounded up to whole cycles
  localparam int CLK_PERIOD_NS = 10;
  localparam int LOTC_TIME_NS  = 5000;
  localparam int LOTC_CYC      = (LOTC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOTC_W        = 10;
  localparam logic [LOTC_W-1:0] LOTC_LIMIT = LOTC_W'(LOTC_CYC);
  // Link clock runs at 16x line rate; line clock is the divider msb
  localparam logic [3:0] RX_RISE_CNT = 4'h7;
  localparam logic [3:0] RX_FALL_CNT = 4'hf;
  // Pattern checker: taps and sync thresholds
  localparam int E1_TAP_A = 14;
  localparam int E1_TAP_B = 13;
  localparam int T1_TAP_A = 19;
  localparam int T1_TAP_B = 16;
  localparam logic [5:0] SYNC_GOOD = 6'h1f;
  localparam logic [1:0] LOSE_BAD  = 2'h3;

  typedef struct packed {
    logic       line_std;
    logic       single_rail;
    logic       rx_edge;
    logic       tx_edge;
    logic       loss_sel;
    logic       err_cnt_en;
    logic [1:0] bp_rate;
  } lcsi_cfg_s;

  typedef struct packed {
    logic pos;
    logic neg;
    logic err;
  } lcsi_rxin_s;

  typedef struct packed {
    logic pos;
    logic neg;
    logic pat_err;
    logic bp_clk;
    logic rclk;
  } lcsi_rxout_s;
endpackage

// >>> hw/lcsi_sync2.sv
// Purpose: Two flip-flop level synchroniser.
// Assumes: Inputs are levels or slow toggles relative to clk.
// Notes:   First stage feeds only the second stage.
module lcsi_sync2 import lcsi_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } lcsi_sy_s;
  lcsi_sy_s s_r;
  lcsi_sy_s s_nxt;

  always_comb begin
    s_nxt      = s_r;
    s_nxt.meta = d;
    s_nxt.q    = s_r.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule

// >>> hw/lcsi_rx_chan.sv
// Purpose: Link-side logic of one channel: receive outputs, pattern check, backplane clock.
// Assumes: link_clk is the recovered reference at 16x line rate, running free when no signal.
// Notes:   Config arrives from the register domain and is resynchronised as quasi-static levels.
module lcsi_rx_chan import lcsi_pkg::*; (
  input  wire logic        link_clk,
  input  wire logic        rst_n,
  input  lcsi_cfg_s        cfg,
  input  lcsi_rxin_s       rx,
  output lcsi_rxout_s      out,
  output logic             err_tgl,
  output logic             in_sync
);
  typedef struct packed {
    logic [3:0]  cnt;
    logic [19:0] sh;
    logic [5:0]  good;
    logic [1:0]  bad;
    logic        sync;
    logic        tgl;
    lcsi_rxout_s o;
  } lcsi_ch_s;
  lcsi_ch_s  s_r;
  lcsi_ch_s  s_nxt;
  lcsi_cfg_s c;
  logic      bit_stb;
  logic      data;
  logic      expect_bit;
  logic      miss;

  lcsi_sync2 #(.W(8)) u_cfg_sync (
    .clk   (link_clk),
    .rst_n (rst_n),
    .d     (cfg),
    .q     (c)
  );

  always_comb begin
    s_nxt      = s_r;
    bit_stb    = (s_r.cnt == (c.rx_edge ? RX_FALL_CNT : RX_RISE_CNT)); // [R11]
    data       = rx.pos | rx.neg;
    expect_bit = c.line_std ? (s_r.sh[T1_TAP_A] ^ s_r.sh[T1_TAP_B])
                            : (s_r.sh[E1_TAP_A] ^ s_r.sh[E1_TAP_B]); // [R4]
    miss       = data ^ expect_bit;
    // Free-running divider keeps the line clock alive without a signal
    s_nxt.cnt      = s_r.cnt + 4'h1; // [R13]
    s_nxt.o.rclk   = s_nxt.cnt[3];
    s_nxt.o.bp_clk = s_nxt.cnt[2'd3 - c.bp_rate]; // [R10]
    if (bit_stb) begin
      s_nxt.sh    = {s_r.sh[18:0], data};
      s_nxt.o.pos = c.single_rail ? data : rx.pos; // [R11] [R12]
      s_nxt.o.neg = c.single_rail ? rx.err : rx.neg; // [R12]
      if (!s_r.sync) begin
        s_nxt.bad = 2'h0;
        if (miss) begin
          s_nxt.good = 6'h00;
        end else if (s_r.good == SYNC_GOOD) begin
          s_nxt.sync = 1'b1;
        end else begin
          s_nxt.good = s_r.good + 6'h01;
        end
      end else if (miss) begin
        s_nxt.tgl = ~s_r.tgl; // [R7]
        s_nxt.bad = s_r.bad + 2'h1;
        if (s_r.bad == LOSE_BAD) begin
          s_nxt.sync = 1'b0;
          s_nxt.good = 6'h00;
        end
      end else begin
        s_nxt.bad = 2'h0;
      end
      // High while hunting, one bit period pulse per error once locked
      s_nxt.o.pat_err = ~s_nxt.sync | (s_r.sync & miss); // [R5] [R6]
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '{cnt: 4'h0, sh: 20'h00000, good: 6'h00, bad: 2'h0, sync: 1'b0, tgl: 1'b0,
               o: '{pos: 1'b0, neg: 1'b0, pat_err: 1'b1, bp_clk: 1'b0, rclk: 1'b0}};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign out     = s_r.o;
  assign err_tgl = s_r.tgl;
  assign in_sync = s_r.sync;

  a_hunt_pat_high: assert property (@(posedge link_clk) disable iff (!rst_n) // [R5]
    (bit_stb && !s_r.sync && (miss || s_r.good != SYNC_GOOD)) |=> out.pat_err [*8])
    else $error("pattern error low while hunting");
  a_nrz_err_neg: assert property (@(posedge link_clk) disable iff (!rst_n) // [R12]
    (bit_stb && c.single_rail) |=> (out.neg == $past(rx.err)) && (out.pos == $past(data)))
    else $error("single rail outputs wrong");
  a_err_pulse_w: assert property (@(posedge link_clk) disable iff (!rst_n) // [R6]
    (bit_stb && s_r.sync && miss && s_r.bad != LOSE_BAD) |=>
    out.pat_err [*8] ##1 out.pat_err [*8] ##1 (!out.pat_err || $past(miss)))
    else $error("pattern error pulse width wrong");
endmodule

// >>> hw/lcsi_top.sv
// Purpose: System-side pin logic of four line-interface channels with register port.
// Assumes: Host logic on CLK drives the register port; transmit pins and serial pins are asynchronous.
// Notes:   Receive-side outputs except PATTERN_IN_SYNC run on each channel's own link clock.

// What this block does
// R1: Host holds a channel's select low to access that channel's registers.
// R2: Serial input sampled on serial clock rise when edge select 0, fall when 1.
// R3: Serial output changes on serial clock rise when edge select 1, fall when 0.
// R4: Receiver hunts 2^15-1 pattern for E1 or 2^20-1 pattern for T1 per line standard.
// R5: Pattern error output high while unsynchronised, low once locked.
// R6: Each locked bit error gives one line-bit-wide high pulse on pattern error.
// R7: With count enable set, pattern errors accumulate in the error count registers.
// R8: Loss output shows carrier loss, or transmit clock idle 5 us when selected.
// R9: Hardware mode forces loss select to zero.
// R10: Backplane clock at 16.384, 8.192, 4.096 or 2.048 MHz, two bits choose.
// R11: Receive outputs update on recovered clock rise (edge bit 0) or fall (1).
// R12: Single-rail mode: data on positive output, line errors pulse negative output.
// R13: Recovered clock keeps running without a line signal.
// R14: Transmit positive data sampled on tx clock fall (edge 0) or rise (1).
// R15: Transmit negative data follows the same edge choice.
// R16: Hardware reset low returns all control bits to zero.
// R17: In hardware mode the line standard pin picks E1 (0) or T1 (1).
// R18: Four independent channels, each with its own control bits.
module lcsi_top import lcsi_pkg::*; (
  input  wire logic            CLK,
  input  wire logic            RST_N,
  input  wire logic [AW-1:0]   ADDR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WR,
  input  wire logic            RD,
  output logic      [7:0]      RDATA,
  input  wire logic [NCH-1:0]  CHANNEL_SELECT_N,
  input  wire logic            HW_RESET_N,
  input  wire logic            HW_MODE,
  input  wire logic            HW_LINE_STANDARD_SELECT,
  input  wire logic            SER_CLK,
  input  wire logic            SER_PORT_IN,
  output logic                 SER_PORT_OUT,
  input  wire logic            INPUT_EDGE_SELECT,
  input  wire logic            OUTPUT_EDGE_SELECT,
  input  wire logic [NCH-1:0]  TX_LINE_CLK,
  input  wire logic [NCH-1:0]  TX_POS_DATA,
  input  wire logic [NCH-1:0]  TX_NEG_DATA,
  output logic      [NCH-1:0]  TX_POS_SAMPLED,
  output logic      [NCH-1:0]  TX_NEG_SAMPLED,
  input  wire logic [NCH-1:0]  RX_CARRIER_LOSS,
  output logic      [NCH-1:0]  LOSS_INDICATOR_OUT,
  input  wire logic [NCH-1:0]  LINK_CLK,
  input  wire logic [NCH-1:0]  RX_POS_IN,
  input  wire logic [NCH-1:0]  RX_NEG_IN,
  input  wire logic [NCH-1:0]  RX_LINE_ERR,
  output logic      [NCH-1:0]  RX_POS_DATA,
  output logic      [NCH-1:0]  RX_NEG_DATA,
  output logic      [NCH-1:0]  PATTERN_ERROR_OUT,
  output logic      [NCH-1:0]  BACKPLANE_CLK_OUT,
  output logic      [NCH-1:0]  RX_CLK_OUT,
  output logic      [NCH-1:0]  PATTERN_IN_SYNC
);
  localparam int SW = 6 * NCH + 7;

  typedef struct packed {
    lcsi_cfg_s [NCH-1:0]        cfg;
    lcsi_cfg_s [NCH-1:0]        eff;
    logic [NCH-1:0][15:0]       errcnt;
    logic [NCH-1:0][LOTC_W-1:0] idle;
    logic [NCH-1:0]             tx_line_clk_q;
    logic [NCH-1:0]             tx_pos_data;
    logic [NCH-1:0]             tx_neg_data;
    logic [NCH-1:0]             loss;
    logic [NCH-1:0]             etgl_q;
    logic                       sclk_q;
    logic [7:0]                 ser_in;
    logic [7:0]                 ser_out;
    logic [7:0]                 rdata;
  } lcsi_top_s;
  lcsi_top_s s_r;
  lcsi_top_s s_nxt;

  logic [SW-1:0]  sy;
  logic [NCH-1:0] tx_line_clk_s;
  logic [NCH-1:0] tx_pos_data_s;
  logic [NCH-1:0] tx_neg_data_s;
  logic [NCH-1:0] closs_s;
  logic [NCH-1:0] etgl_s;
  logic [NCH-1:0] sync_s;
  logic           sclk_s;
  logic           sdi_s;
  logic           ies_s;
  logic           oes_s;
  logic           hw_mode_s;
  logic           hw_std_s;
  logic           hw_rst_n_s;
  logic [NCH-1:0] err_tgl;
  logic [NCH-1:0] in_sync;
  logic [NCH-1:0] take;
  logic [NCH-1:0] err_ev;
  logic [NCH-1:0] sel;
  logic [1:0]     rch;
  logic           s_rise;
  logic           s_fall;

  // Every pin except the register port, RST_N and the link-side receive pins, and every link-domain status, passes two flops before use
  lcsi_sync2 #(.W(SW)) u_pin_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({TX_LINE_CLK, TX_POS_DATA, TX_NEG_DATA, RX_CARRIER_LOSS, err_tgl, in_sync,
             SER_CLK, SER_PORT_IN, INPUT_EDGE_SELECT, OUTPUT_EDGE_SELECT,
             HW_MODE, HW_LINE_STANDARD_SELECT, HW_RESET_N}),
    .q     (sy)
  );
  assign {tx_line_clk_s, tx_pos_data_s, tx_neg_data_s, closs_s, etgl_s, sync_s,
          sclk_s, sdi_s, ies_s, oes_s, hw_mode_s, hw_std_s, hw_rst_n_s} = sy;

  for (genvar i = 0; i < NCH; i++) begin : g_ch // [R18]
    lcsi_rxout_s ro;
    lcsi_rx_chan u_chan (
      .link_clk (LINK_CLK[i]),
      .rst_n    (RST_N),
      .cfg      (s_r.eff[i]),
      .rx       ('{pos: RX_POS_IN[i], neg: RX_NEG_IN[i], err: RX_LINE_ERR[i]}),
      .out      (ro),
      .err_tgl  (err_tgl[i]),
      .in_sync  (in_sync[i])
    );
    assign RX_POS_DATA[i]       = ro.pos;
    assign RX_NEG_DATA[i]       = ro.neg;
    assign PATTERN_ERROR_OUT[i] = ro.pat_err;
    assign BACKPLANE_CLK_OUT[i] = ro.bp_clk;
    assign RX_CLK_OUT[i]        = ro.rclk;
  end

  always_comb begin
    s_nxt  = s_r;
    sel    = ~CHANNEL_SELECT_N; // [R1]
    rch    = 2'd0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (sel[i]) begin
        rch = 2'(i);
      end
    end
    s_rise = sclk_s & ~s_r.sclk_q;
    s_fall = ~sclk_s & s_r.sclk_q;
    s_nxt.sclk_q = sclk_s;
    s_nxt.tx_line_clk_q = tx_line_clk_s;
    s_nxt.etgl_q = etgl_s;
    s_nxt.rdata  = 8'h00;
    for (int i = 0; i < NCH; i++) begin
      take[i]   = s_r.eff[i].tx_edge ? (tx_line_clk_s[i] & ~s_r.tx_line_clk_q[i]) : (~tx_line_clk_s[i] & s_r.tx_line_clk_q[i]);
      err_ev[i] = (etgl_s[i] != s_r.etgl_q[i]) & s_r.eff[i].err_cnt_en;
      if (take[i]) begin
        s_nxt.tx_pos_data[i] = tx_pos_data_s[i]; // [R14]
        s_nxt.tx_neg_data[i] = tx_neg_data_s[i]; // [R15]
      end
      // Any transmit clock edge restarts the idle timer
      if (tx_line_clk_s[i] != s_r.tx_line_clk_q[i]) begin
        s_nxt.idle[i] = '0;
      end else if (s_r.idle[i] != LOTC_LIMIT) begin
        s_nxt.idle[i] = s_r.idle[i] + LOTC_W'(1);
      end
      s_nxt.loss[i] = s_r.eff[i].loss_sel ? (s_r.idle[i] == LOTC_LIMIT) : closs_s[i]; // [R8]
      if (WR && sel[i] && ADDR == ADDR_CTRL) begin
        s_nxt.cfg[i] = lcsi_cfg_s'(WDATA);
      end
      // A counted error in the clearing cycle survives as a count of one
      if (WR && sel[i] && ADDR == ADDR_ERR_LO) begin
        s_nxt.errcnt[i] = ERRCNT_RST;
      end
      if (err_ev[i]) begin
        s_nxt.errcnt[i] = s_nxt.errcnt[i] + 16'h0001; // [R7]
      end
      if (!hw_rst_n_s) begin
        s_nxt.cfg[i]    = lcsi_cfg_s'(CTRL_RST); // [R16]
        s_nxt.errcnt[i] = ERRCNT_RST;
      end
      s_nxt.eff[i] = s_nxt.cfg[i];
      if (hw_mode_s) begin
        s_nxt.eff[i].line_std = hw_std_s; // [R17]
        s_nxt.eff[i].loss_sel = 1'b0; // [R9]
      end
    end
    if ((ies_s && s_fall) || (!ies_s && s_rise)) begin
      s_nxt.ser_in = {s_r.ser_in[6:0], sdi_s}; // [R2]
    end
    if (WR && |sel && ADDR == ADDR_SER_TX) begin
      s_nxt.ser_out = WDATA;
    end else if ((oes_s && s_rise) || (!oes_s && s_fall)) begin
      s_nxt.ser_out = {s_r.ser_out[6:0], 1'b0}; // [R3]
    end
    if (RD && |sel) begin
      case (ADDR)
        ADDR_CTRL:   s_nxt.rdata = s_r.cfg[rch];
        ADDR_STATUS: s_nxt.rdata = {6'h00, s_r.loss[rch], sync_s[rch]};
        ADDR_ERR_LO: s_nxt.rdata = s_r.errcnt[rch][7:0];
        ADDR_ERR_HI: s_nxt.rdata = s_r.errcnt[rch][15:8];
        ADDR_SER_RX: s_nxt.rdata = s_r.ser_in;
        ADDR_SER_TX: s_nxt.rdata = s_r.ser_out;
        default:     s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_r <= '{cfg: {NCH{CTRL_RST}}, eff: {NCH{CTRL_RST}}, errcnt: {NCH{ERRCNT_RST}},
               idle: '0, tx_line_clk_q: '0, tx_pos_data: '0, tx_neg_data: '0, loss: '0, etgl_q: '0,
               sclk_q: 1'b0, ser_in: SER_RST, ser_out: SER_RST, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA              = s_r.rdata;
  assign SER_PORT_OUT       = s_r.ser_out[7];
  assign TX_POS_SAMPLED     = s_r.tx_pos_data;
  assign TX_NEG_SAMPLED     = s_r.tx_neg_data;
  assign LOSS_INDICATOR_OUT = s_r.loss;
  // Status only; sync flag comes through the pin synchroniser
  assign PATTERN_IN_SYNC    = sync_s;

  a_read_one_cycle: assert property (@(posedge CLK) disable iff (!RST_N) // [R1]
    (!RD || CHANNEL_SELECT_N == '1) |=> RDATA == 8'h00)
    else $error("read data outside its cycle or without select");
  a_ctrl_write_read: assert property (@(posedge CLK) disable iff (!RST_N) // [R18]
    (WR && CHANNEL_SELECT_N == 4'he && ADDR == ADDR_CTRL && hw_rst_n_s) ##1 (!WR && hw_rst_n_s) ##1
    (RD && CHANNEL_SELECT_N == 4'he && ADDR == ADDR_CTRL && hw_rst_n_s) |=> RDATA == $past(WDATA, 3))
    else $error("control register readback mismatch");
  a_tx_pos_edge: assert property (@(posedge CLK) disable iff (!RST_N) // [R14] [R15]
    (s_r.eff[0].tx_edge ? $rose(tx_line_clk_s[0]) : $fell(tx_line_clk_s[0])) |=>
    TX_POS_SAMPLED[0] == $past(tx_pos_data_s[0]) && TX_NEG_SAMPLED[0] == $past(tx_neg_data_s[0]))
    else $error("transmit data not taken on selected edge");
  a_lotc_loss: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    (s_r.eff[0].loss_sel && s_r.idle[0] == LOTC_LIMIT && $stable(tx_line_clk_s[0])) |=> LOSS_INDICATOR_OUT[0])
    else $error("loss of transmit clock not flagged");
  a_carrier_loss: assert property (@(posedge CLK) disable iff (!RST_N) // [R8]
    (!s_r.eff[1].loss_sel && closs_s[1]) |=> LOSS_INDICATOR_OUT[1])
    else $error("carrier loss not flagged");
  a_hw_loss_sel: assert property (@(posedge CLK) disable iff (!RST_N) // [R9] [R17]
    hw_mode_s [*2] |-> !s_r.eff[2].loss_sel && s_r.eff[2].line_std == $past(hw_std_s))
    else $error("hardware mode overrides missing");
  a_hw_reset_clr: assert property (@(posedge CLK) disable iff (!RST_N) // [R16]
    !hw_rst_n_s |=> s_r.cfg == '0 && s_r.errcnt[3] <= 16'h0001)
    else $error("hardware reset left control bits set");
  a_err_count: assert property (@(posedge CLK) disable iff (!RST_N) // [R7]
    (err_ev[0] && !WR && hw_rst_n_s) |=> s_r.errcnt[0] == $past(s_r.errcnt[0]) + 16'h0001)
    else $error("pattern error not counted");
  a_ser_in_edge: assert property (@(posedge CLK) disable iff (!RST_N) // [R2]
    (ies_s ? s_fall : s_rise) |=> s_r.ser_in[0] == $past(sdi_s))
    else $error("serial input not sampled on selected edge");
  a_ser_out_edge: assert property (@(posedge CLK) disable iff (!RST_N) // [R3]
    (!WR && (oes_s ? s_fall : s_rise)) |=> $stable(SER_PORT_OUT))
    else $error("serial output moved on wrong edge");
endmodule

// >>> dv/lcsi_far_model.sv
// Purpose: Far-side model: framer driving transmit pins and line receive data for all channels.
// Assumes: Link clocks at 12 ns; receive bits change at count 12, clear of both sampling counts.
// Notes:   A toggle on inj_tgl flips one pattern bit and flags that bit as a line error.
module lcsi_far_model import lcsi_pkg::*; (
  input  wire logic           rst_n,
  input  wire logic           tx_run,
  input  wire logic           inj_tgl,
  output logic      [NCH-1:0] link_clk,
  output logic      [NCH-1:0] rx_pos,
  output logic      [NCH-1:0] rx_neg,
  output logic      [NCH-1:0] rx_err,
  output logic      [NCH-1:0] tx_clk,
  output logic      [NCH-1:0] tx_pos,
  output logic      [NCH-1:0] tx_neg
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [14:0] prbs;
  logic [3:0]  cnt;
  logic        inj_seen;
  logic        ph;
  logic        nb;
  logic [7:0]  k;

  initial begin
    link_clk = '0;
    #2.7;
    forever #6 link_clk = ~link_clk;
  end

  // Marks alternate between the rails so the checker must merge both
  always @(posedge link_clk[0] or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      prbs <= 15'h0001;
      inj_seen <= inj_tgl;
      ph <= 1'b0;
      rx_pos <= '0;
      rx_neg <= '0;
      rx_err <= '0;
    end else begin
      cnt <= cnt + 4'h1;
      if (cnt == 4'hc) begin
        nb = prbs[14] ^ prbs[13];
        prbs <= {prbs[13:0], nb};
        rx_err <= {NCH{inj_tgl != inj_seen}};
        nb = nb ^ (inj_tgl != inj_seen);
        inj_seen <= inj_tgl;
        ph <= ph ^ nb;
        rx_pos <= {NCH{nb & ph}};
        rx_neg <= {NCH{nb & ~ph}};
      end
    end
  end

  // Data moves a quarter period after the rising edge, so the two edges see different bits
  initial begin
    tx_clk = '0;
    tx_pos = '0;
    tx_neg = '0;
    k = 8'h5a;
    forever begin
      if (tx_run) begin
        tx_clk = '1;
        #100;
        k = k * 8'h05 + 8'h03;
        tx_pos = k[3:0];
        tx_neg = k[7:4];
        #100;
        tx_clk = '0;
        #200;
      end else begin
        #10;
      end
    end
  end
endmodule

// >>> dv/lcsi_top_tb.sv
// Purpose: Self-checking bench for the four-channel line-interface pin logic.
// Assumes: CLK 10 ns, link clocks from the far-side model, serial clock paced by the bench.
// Notes:   Register reads are noted in a queue and compared by a watcher one cycle later.
module lcsi_top_tb import lcsi_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic           CLK, RST_N, WR, RD, HW_RESET_N, HW_MODE, SER_CLK, SER_PORT_IN, HW_LINE_STANDARD_SELECT;
  logic           INPUT_EDGE_SELECT, OUTPUT_EDGE_SELECT, SER_PORT_OUT, tx_run, inj_tgl, rd_d, edge_on;
  logic [AW-1:0]  ADDR;
  logic [7:0]     WDATA, RDATA, v;
  logic [NCH-1:0] CHANNEL_SELECT_N, RX_CARRIER_LOSS, LOSS_INDICATOR_OUT, LINK_CLK, RX_POS_IN, RX_NEG_IN;
  logic [NCH-1:0] RX_LINE_ERR, RX_POS_DATA, RX_NEG_DATA, PATTERN_ERROR_OUT, BACKPLANE_CLK_OUT, RX_CLK_OUT;
  logic [NCH-1:0] PATTERN_IN_SYNC, TX_LINE_CLK, TX_POS_DATA, TX_NEG_DATA, TX_POS_SAMPLED, TX_NEG_SAMPLED;
  logic [NCH-1:0] pd, pc;
  logic [7:0]     q[$];
  logic [7:0]     rc[NCH];
  logic [7:0]     base[NCH] = '{8'h04, 8'h04, 8'h44, 8'h24};
  int             fails, checks_done, cyc, n, n2;
  int             seed = 83752;

  lcsi_top u_lcsi_top (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .CHANNEL_SELECT_N(CHANNEL_SELECT_N), .HW_RESET_N(HW_RESET_N), .HW_MODE(HW_MODE),
    .HW_LINE_STANDARD_SELECT(HW_LINE_STANDARD_SELECT), .SER_CLK(SER_CLK), .SER_PORT_IN(SER_PORT_IN),
    .SER_PORT_OUT(SER_PORT_OUT), .INPUT_EDGE_SELECT(INPUT_EDGE_SELECT), .OUTPUT_EDGE_SELECT(OUTPUT_EDGE_SELECT),
    .TX_LINE_CLK(TX_LINE_CLK), .TX_POS_DATA(TX_POS_DATA), .TX_NEG_DATA(TX_NEG_DATA),
    .TX_POS_SAMPLED(TX_POS_SAMPLED), .TX_NEG_SAMPLED(TX_NEG_SAMPLED), .RX_CARRIER_LOSS(RX_CARRIER_LOSS),
    .LOSS_INDICATOR_OUT(LOSS_INDICATOR_OUT), .LINK_CLK(LINK_CLK), .RX_POS_IN(RX_POS_IN), .RX_NEG_IN(RX_NEG_IN),
    .RX_LINE_ERR(RX_LINE_ERR), .RX_POS_DATA(RX_POS_DATA), .RX_NEG_DATA(RX_NEG_DATA),
    .PATTERN_ERROR_OUT(PATTERN_ERROR_OUT), .BACKPLANE_CLK_OUT(BACKPLANE_CLK_OUT), .RX_CLK_OUT(RX_CLK_OUT),
    .PATTERN_IN_SYNC(PATTERN_IN_SYNC));

  lcsi_far_model u_lcsi_far_model (.rst_n(RST_N), .tx_run(tx_run), .inj_tgl(inj_tgl), .link_clk(LINK_CLK),
    .rx_pos(RX_POS_IN), .rx_neg(RX_NEG_IN), .rx_err(RX_LINE_ERR), .tx_clk(TX_LINE_CLK),
    .tx_pos(TX_POS_DATA), .tx_neg(TX_NEG_DATA));

  always #5 CLK = ~CLK;

  task automatic chk(string nm, logic [15:0] exp, logic [15:0] got);
    checks_done++;
    if (exp !== got) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic results();
    if (fails == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic wr(logic [3:0] s, logic [AW-1:0] a, logic [7:0] d);
    @(posedge CLK);
    CHANNEL_SELECT_N <= s;
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rd(logic [3:0] s, logic [AW-1:0] a, logic [7:0] e);
    @(posedge CLK);
    CHANNEL_SELECT_N <= s;
    ADDR <= a;
    RD <= 1'b1;
    q.push_back(e);
    @(posedge CLK);
    RD <= 1'b0;
  endtask

  // Data flips between the two serial clock edges, so each edge choice captures a distinct byte
  task automatic ser(logic ies, logic oes, logic [7:0] b, logic [7:0] t);
    logic [7:0] x;
    INPUT_EDGE_SELECT <= ies;
    OUTPUT_EDGE_SELECT <= oes;
    wr(4'he, ADDR_SER_TX, t);
    x = t;
    for (int i = 7; i >= 0; i--) begin
      SER_PORT_IN <= b[i];
      repeat (8) @(posedge CLK);
      SER_CLK <= 1'b1;
      repeat (8) @(posedge CLK);
      if (oes) x = x << 1;
      chk("ser_out_rise", x[7], SER_PORT_OUT);
      SER_PORT_IN <= ~b[i];
      repeat (8) @(posedge CLK);
      SER_CLK <= 1'b0;
      repeat (8) @(posedge CLK);
      if (!oes) x = x << 1;
      chk("ser_out_fall", x[7], SER_PORT_OUT);
    end
    rd(4'he, ADDR_SER_RX, ies ? ~b : b);
  endtask

  task automatic period(input bit w, output int p_n);
    logic p, s;
    int   e;
    e = 0;
    p_n = 0;
    p = 1'b1;
    for (int i = 0; i < 80 && e < 2; i++) begin
      @(posedge LINK_CLK[0]);
      s = w ? RX_CLK_OUT[0] : BACKPLANE_CLK_OUT[0];
      if (s === 1'b1 && p === 1'b0) e++;
      if (e == 1) p_n++;
      p = s;
    end
  endtask

  always @(posedge CLK) begin
    rd_d <= RD;
    if (rd_d === 1'b1) chk("rdata", q.pop_front(), RDATA);
    cyc++;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  // Channel 0 launches on the recovered clock rise, channel 3 on its fall
  always @(posedge LINK_CLK[0]) begin
    if (edge_on) for (int k = 0; k < NCH; k += 3)
      if (RX_POS_DATA[k] !== pd[k]) chk("rx_edge", k == 0 ? 2'b01 : 2'b10, {pc[k], RX_CLK_OUT[k]});
    pd <= RX_POS_DATA;
    pc <= RX_CLK_OUT;
  end

  initial begin
    {CLK, RST_N, WR, RD, HW_MODE, SER_CLK, SER_PORT_IN, INPUT_EDGE_SELECT, OUTPUT_EDGE_SELECT} = '0;
    {HW_RESET_N, tx_run, inj_tgl, rd_d, edge_on, HW_LINE_STANDARD_SELECT} = 6'b110000;
    {ADDR, WDATA, CHANNEL_SELECT_N, RX_CARRIER_LOSS} = {3'h0, 8'h00, 4'hf, 4'h0};
    {fails, checks_done, cyc} = '0;
    repeat (4) @(posedge CLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 6; a++) rd(4'he, a[AW-1:0], 8'h00);
    chk("pat_err_hunt", 4'hf, PATTERN_ERROR_OUT);
    for (int c = 0; c < NCH; c++) begin
      rc[c] = 8'($random(seed));
      wr(~(4'h1 << c), ADDR_CTRL, rc[c]);
    end
    for (int c = 0; c < NCH; c++) rd(~(4'h1 << c), ADDR_CTRL, rc[c]);
    // Write then read back one channel with a single idle cycle between
    wr(4'he, ADDR_CTRL, ~rc[0]);
    rd(4'he, ADDR_CTRL, ~rc[0]);
    rd(4'hf, ADDR_CTRL, 8'h00);
    rd(4'he, 3'h6, 8'h00);
    HW_RESET_N <= 1'b0;
    repeat (5) @(posedge CLK);
    HW_RESET_N <= 1'b1;
    repeat (3) @(posedge CLK);
    for (int c = 0; c < NCH; c++) rd(~(4'h1 << c), ADDR_CTRL, 8'h00);
    for (int te = 0; te < 2; te++) begin
      for (int c = 0; c < NCH; c++) wr(~(4'h1 << c), ADDR_CTRL, base[c] | 8'(te << 4));
      repeat (8) begin
        if (te == 1) @(posedge TX_LINE_CLK[0]);
        else @(negedge TX_LINE_CLK[0]);
        v = {TX_POS_DATA, TX_NEG_DATA};
        repeat (18) @(posedge CLK);
        chk("tx_sampled", v, {TX_POS_SAMPLED, TX_NEG_SAMPLED});
      end
    end
    RX_CARRIER_LOSS <= 4'h5;
    repeat (10) @(posedge CLK);
    chk("loss_carrier", 4'h5, LOSS_INDICATOR_OUT);
    wr(4'h0, ADDR_CTRL, 8'h1c);
    @(negedge TX_LINE_CLK[0]);
    tx_run <= 1'b0;
    repeat (480) @(posedge CLK);
    chk("loss_txclk_early", 4'h0, LOSS_INDICATOR_OUT);
    repeat (40) @(posedge CLK);
    chk("loss_txclk", 4'hf, LOSS_INDICATOR_OUT);
    HW_MODE <= 1'b1;
    HW_LINE_STANDARD_SELECT <= 1'b1;
    RX_CARRIER_LOSS <= 4'h3;
    repeat (10) @(posedge CLK);
    chk("loss_hw_mode", 4'h3, LOSS_INDICATOR_OUT);
    HW_MODE <= 1'b0;
    RX_CARRIER_LOSS <= 4'h0;
    tx_run <= 1'b1;
    repeat (40) @(posedge CLK);
    chk("loss_txclk_back", 4'h0, LOSS_INDICATOR_OUT);
    for (int r = 0; r < 4; r++) begin
      wr(4'h0, ADDR_CTRL, 8'h04 | 8'(r));
      repeat (20) @(posedge CLK);
      period(1'b0, n);
      chk("bp_period", 16'(16 >> r), 16'(n));
    end
    period(1'b1, n);
    chk("rx_clk_period", 16'h0010, 16'(n));
    for (int c = 0; c < NCH; c++) wr(~(4'h1 << c), ADDR_CTRL, base[c]);
    repeat (1500) @(posedge CLK);
    edge_on <= 1'b1;
    chk("in_sync", 4'hf, PATTERN_IN_SYNC);
    chk("pat_err_locked", 4'h0, PATTERN_ERROR_OUT);
    rd(4'he, ADDR_STATUS, 8'h01);
    wr(4'h0, ADDR_ERR_LO, 8'h00);
    n = 0;
    n2 = 0;
    inj_tgl <= ~inj_tgl;
    repeat (640) @(posedge LINK_CLK[0]) begin
      n += int'(PATTERN_ERROR_OUT[0]);
      n2 += int'(RX_NEG_DATA[2]);
    end
    chk("pat_err_width", 16'h0030, 16'(n));
    chk("nrz_err_pulse", 16'h0010, 16'(n2));
    rd(4'he, ADDR_ERR_LO, 8'h03);
    rd(4'he, ADDR_ERR_HI, 8'h00);
    wr(4'hd, ADDR_CTRL, 8'h84);
    repeat (3000) @(posedge CLK);
    chk("t1_unsync", 2'b10, {PATTERN_ERROR_OUT[1], PATTERN_IN_SYNC[1]});
    for (int j = 0; j < 4; j++) ser(j[0], j[1], 8'($random(seed)), 8'($random(seed)));
    repeat (4) @(posedge CLK);
    results();
  end
endmodule
